/* design/mmsa_limit_alarm.sv */
`timescale 1ns/1ps
module mmsa_limit_alarm (
  input wire logic clk, // system clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic secTick, // one-cycle pulse once a second
  input wire logic [13:0] reading, // measured reading
  input wire logic [13:0] limitVal, // limit value
  input wire logic [13:0] deadband, // total hysteresis
  input wire logic senseHigh, // 1: energize above, 0: below
  input wire logic [13:0] makeDelay, // seconds before energizing
  input wire logic [13:0] breakDelay, // seconds before de-energizing
  output logic alarmOut // relay drive
);
  logic [14:0] halfBand; // half the deadband each side
  logic [14:0] upper; // limit plus half band
  logic [14:0] lower; // limit minus half band, floored at zero
  logic above; // reading beyond the upper edge
  logic below; // reading beyond the lower edge
  logic cond_ff; // alarm condition with hysteresis
  logic alarm_ff; // relay state after delays
  logic [13:0] delayCnt_ff; // seconds the condition has differed

  // split the deadband evenly around the limit
  assign halfBand = {2'h0, deadband[13:1]};
  assign upper = {1'b0, limitVal} + halfBand;
  assign lower = ({1'b0, limitVal} > halfBand) ? ({1'b0, limitVal} - halfBand) : 15'h0000;
  assign above = {1'b0, reading} > upper;
  assign below = {1'b0, reading} < lower;
  assign alarmOut = alarm_ff;

  // hysteretic condition; inside the band it keeps its last value
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cond_ff <= 1'b0;
    end else if (senseHigh) begin
      if (above) begin
        cond_ff <= 1'b1;
      end else if (below) begin
        cond_ff <= 1'b0;
      end
    end else begin
      if (below) begin
        cond_ff <= 1'b1;
      end else if (above) begin
        cond_ff <= 1'b0;
      end
    end
  end

  // whole seconds of disagreement; any return to agreement restarts it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      delayCnt_ff <= 14'h0000;
    end else if (cond_ff == alarm_ff) begin
      delayCnt_ff <= 14'h0000;
    end else if (secTick && delayCnt_ff != mmsa_pkg::VAL_MAX) begin
      delayCnt_ff <= delayCnt_ff + 14'h0001;
    end
  end

  // relay follows the condition once its delay has run out
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarm_ff <= 1'b0;
    end else if (cond_ff && !alarm_ff && delayCnt_ff >= makeDelay) begin
      alarm_ff <= 1'b1;
    end else if (!cond_ff && alarm_ff && delayCnt_ff >= breakDelay) begin
      alarm_ff <= 1'b0;
    end
  end

  a_make_wait: assert property (@(posedge clk) disable iff (!resetn)
    $rose(alarm_ff) |-> $past(cond_ff) && ($past(delayCnt_ff) >= $past(makeDelay)))
    else $error("relay energized before make delay ran out");

  a_break_wait: assert property (@(posedge clk) disable iff (!resetn)
    $fell(alarm_ff) |-> !$past(cond_ff) && ($past(delayCnt_ff) >= $past(breakDelay)))
    else $error("relay released before break delay ran out");

  a_timer_restart: assert property (@(posedge clk) disable iff (!resetn)
    (cond_ff != alarm_ff) ##1 (cond_ff == alarm_ff) |=> delayCnt_ff == 14'h0000)
    else $error("delay count not restarted");

  a_band_split: assert property (@(posedge clk) disable iff (!resetn)
    (senseHigh && $stable(senseHigh) && {1'b0, reading} > upper) |=> cond_ff)
    else $error("condition not set above upper half band");
endmodule

/* design/mmsa_menu_alarms.sv */
// Notes on behaviour
// - operational up/down alone views limits one/two
// - menu up increments, down decrements shown value
// - calibration entry blinks trim name and off/on
// - no analog output: calibration starts at pulses
// - up or down turns trim on, enabling trims
// - high trim clamped to 17-21 mA, 8-10.3 V
// - program after high trim returns to operation
// - pulses each turn limited to 1..9999
// - resolution choice selects one of three ranges
// - pulses, then resolution, then lamp intensity
// - after intensity: span top if fitted, else exit
// - span top, span bottom, then exit
// - span readings 0..9999, any two-count difference
// - span top may sit below span bottom
// - absent relays drop their setpoint steps
// - setpoint entry blinks limit one name, value
// - limits one, two energize after make delay
// - limits one, two release after break delay
// - deadband split half above, half below
// - limits three, four: value and deadband only
// - one sense flag per limit, left first
// - program on sense pattern returns to operation
// - program alone advances to next step
`timescale 1ns/1ps
module mmsa_menu_alarms #(
  parameter int SEC_CYCLES = mmsa_pkg::SECOND_CYCLES, // clocks per second tick
  parameter int BLINK_CYC = mmsa_pkg::BLINK_CYCLES, // clocks per blink phase
  parameter int NUM_LIMITS = mmsa_pkg::NUM_LIMITS // setpoint count, fixed at four
) (
  input wire logic clk, // system clock, 20 MHz
  input wire logic resetn, // asynchronous reset, active low
  input wire logic keyProg, // program button, high while pressed
  input wire logic keyUp, // up button, high while pressed
  input wire logic keyDown, // down button, high while pressed
  input wire logic outFitted, // analog output hardware present
  input wire logic currentMode, // 1: mA output, 0: volt output
  input wire logic [3:0] relayFitted, // relay present, bit 0 is limit one
  input wire logic [13:0] reading, // measured reading
  output mmsa_pkg::mmsa_step_type menuStep, // step whose name is shown
  output logic showName, // 1: display the step name, 0: the value
  output logic [13:0] shownValue, // value on the display
  output logic trimEnabled, // trim menu off/on
  output logic [13:0] outputBottomTrim, // low trim scale factor
  output logic [13:0] outputTopTrim, // high trim, 0.1 mA or 0.01 V
  output logic [13:0] pulsesEachTurn, // pulses per revolution
  output logic [1:0] resolutionChoice, // 0: 0.1, 1: 1, 2: 10 per count
  output logic [1:0] lampIntensity, // brightness level
  output logic [13:0] spanTopReading, // reading for analog top
  output logic [13:0] spanBottomReading, // reading for analog bottom
  output logic [3:0] relayDrive // relay energized, bit 0 is limit one
);
  if (SEC_CYCLES < 2 || SEC_CYCLES >= 2 ** mmsa_pkg::CNT_W ||
      BLINK_CYC < 2 || BLINK_CYC >= 2 ** mmsa_pkg::CNT_W || NUM_LIMITS != 4) begin : g_bad
    $error("unsupported timing counts or limit count");
  end

  // advance order before absent relays are skipped
  function automatic mmsa_pkg::mmsa_step_type rawNext(input mmsa_pkg::mmsa_step_type st,
      input logic trimOn, input logic outFit);
    case (st)
      mmsa_pkg::ST_TRIM_MENU: rawNext = trimOn ? mmsa_pkg::ST_TRIM_LOW : mmsa_pkg::ST_PULSES;
      mmsa_pkg::ST_TRIM_HIGH: rawNext = mmsa_pkg::ST_OPER;
      mmsa_pkg::ST_LAMP: rawNext = outFit ? mmsa_pkg::ST_SPAN_TOP : mmsa_pkg::ST_OPER;
      mmsa_pkg::ST_SPAN_BOT: rawNext = mmsa_pkg::ST_OPER;
      mmsa_pkg::ST_SENSE: rawNext = mmsa_pkg::ST_OPER;
      mmsa_pkg::ST_OPER: rawNext = mmsa_pkg::ST_OPER;
      default: rawNext = mmsa_pkg::mmsa_step_type'(st + 5'h01);
    endcase
  endfunction

  // a setpoint step is present only when its relay is fitted
  function automatic logic stepPresent(input mmsa_pkg::mmsa_step_type st,
      input logic [3:0] fitted);
    if (st >= mmsa_pkg::ST_LIM1 && st <= mmsa_pkg::ST_DB1) begin
      stepPresent = fitted[0];
    end else if (st >= mmsa_pkg::ST_LIM2 && st <= mmsa_pkg::ST_DB2) begin
      stepPresent = fitted[1];
    end else if (st >= mmsa_pkg::ST_LIM3 && st <= mmsa_pkg::ST_DB3) begin
      stepPresent = fitted[2];
    end else if (st >= mmsa_pkg::ST_LIM4 && st <= mmsa_pkg::ST_DB4) begin
      stepPresent = fitted[3];
    end else begin
      stepPresent = 1'b1;
    end
  endfunction

  // walk past steps of absent relays; the sense step always remains
  function automatic mmsa_pkg::mmsa_step_type skipAbsent(input mmsa_pkg::mmsa_step_type st,
      input logic [3:0] fitted);
    mmsa_pkg::mmsa_step_type s;
    s = st;
    for (int i = 0; i < 12; i++) begin
      if (!stepPresent(s, fitted)) begin
        s = mmsa_pkg::mmsa_step_type'(s + 5'h01);
      end
    end
    skipAbsent = s;
  endfunction

  // upper bound of the value edited at a step
  function automatic logic [13:0] stepMax(input mmsa_pkg::mmsa_step_type st, input logic mA);
    case (st)
      mmsa_pkg::ST_TRIM_MENU: stepMax = mmsa_pkg::SWITCH_MAX;
      mmsa_pkg::ST_TRIM_HIGH: stepMax = mA ? mmsa_pkg::TRIM_MA_MAX : mmsa_pkg::TRIM_V_MAX;
      mmsa_pkg::ST_RANGE: stepMax = mmsa_pkg::RANGE_MAX;
      mmsa_pkg::ST_LAMP: stepMax = mmsa_pkg::LAMP_MAX;
      mmsa_pkg::ST_SENSE: stepMax = mmsa_pkg::SENSE_MAX;
      default: stepMax = mmsa_pkg::VAL_MAX;
    endcase
  endfunction

  // lower bound of the value edited at a step
  function automatic logic [13:0] stepMin(input mmsa_pkg::mmsa_step_type st, input logic mA);
    case (st)
      mmsa_pkg::ST_PULSES: stepMin = mmsa_pkg::PULSES_MIN;
      mmsa_pkg::ST_TRIM_HIGH: stepMin = mA ? mmsa_pkg::TRIM_MA_MIN : mmsa_pkg::TRIM_V_MIN;
      default: stepMin = mmsa_pkg::VAL_MIN;
    endcase
  endfunction

  // force a stored value into the range of its step
  function automatic logic [13:0] clampVal(input logic [13:0] v,
      input mmsa_pkg::mmsa_step_type st, input logic mA);
    if (v > stepMax(st, mA)) begin
      clampVal = stepMax(st, mA);
    end else if (v < stepMin(st, mA)) begin
      clampVal = stepMin(st, mA);
    end else begin
      clampVal = v;
    end
  endfunction

  // value held in each slot after reset
  function automatic logic [13:0] resetVal(input logic [4:0] idx);
    case (idx)
      mmsa_pkg::ST_PULSES: resetVal = mmsa_pkg::RST_PULSES;
      mmsa_pkg::ST_RANGE: resetVal = mmsa_pkg::RST_RANGE;
      mmsa_pkg::ST_LAMP: resetVal = mmsa_pkg::RST_LAMP;
      mmsa_pkg::ST_SPAN_TOP: resetVal = mmsa_pkg::RST_SPAN_TOP;
      default: resetVal = mmsa_pkg::RST_OTHER;
    endcase
  endfunction

  logic [2:0] keys; // {down, up, program}
  logic [2:0] heldKeys_ff; // every key seen during the current press
  logic released; // all keys just let go
  logic actProg, actUp, actDn, actCal, actSetp; // one-cycle key actions
  mmsa_pkg::mmsa_step_type step_ff; // current menu step
  mmsa_pkg::mmsa_step_type nxtStep; // step after this edge
  logic [13:0] paramVal_ff [0:mmsa_pkg::STEP_SLOTS-1]; // value store, one slot a step
  logic [13:0] curVal; // value of the current step, clamped
  logic [13:0] nxtVal; // value after an up or down action
  logic [mmsa_pkg::CNT_W-1:0] secCnt_ff; // divider for the second tick
  logic secTick_ff; // one-cycle pulse each second
  logic [mmsa_pkg::CNT_W-1:0] blinkCnt_ff; // time in the current blink phase
  logic showName_ff; // blink phase
  logic [13:0] shownValue_ff; // display value
  logic [3:0] alarm; // relay states from the limit checkers

  // actions fire on release, so a two-key combination is seen whole
  assign keys = {keyDown, keyUp, keyProg};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      heldKeys_ff <= 3'h0;
    end else begin
      heldKeys_ff <= (|keys) ? (heldKeys_ff | keys) : 3'h0;
    end
  end
  assign released = (heldKeys_ff != 3'h0) && !(|keys);
  assign actProg = released && heldKeys_ff == mmsa_pkg::COMBO_PROG;
  assign actUp = released && heldKeys_ff == mmsa_pkg::COMBO_UP;
  assign actDn = released && heldKeys_ff == mmsa_pkg::COMBO_DN;
  assign actCal = released && heldKeys_ff == mmsa_pkg::COMBO_CAL;
  assign actSetp = released && heldKeys_ff == mmsa_pkg::COMBO_SETP;

  // step sequencing
  always_comb begin
    nxtStep = step_ff;
    case (step_ff)
      mmsa_pkg::ST_OPER: begin
        if (actCal) begin
          nxtStep = outFitted ? mmsa_pkg::ST_TRIM_MENU : mmsa_pkg::ST_PULSES;
        end else if (actSetp) begin
          nxtStep = skipAbsent(mmsa_pkg::ST_LIM1, relayFitted);
        end
      end
      default: begin
        if (actProg) begin
          nxtStep = skipAbsent(rawNext(step_ff, paramVal_ff[mmsa_pkg::ST_TRIM_MENU][0],
                                       outFitted), relayFitted);
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_ff <= mmsa_pkg::ST_OPER;
    end else begin
      step_ff <= nxtStep;
    end
  end

  // edit: up and down step the value, clamped; the trim prompt only turns on
  assign curVal = clampVal(paramVal_ff[step_ff], step_ff, currentMode);
  always_comb begin
    nxtVal = curVal;
    if (step_ff == mmsa_pkg::ST_TRIM_MENU && (actUp || actDn)) begin
      nxtVal = 14'h0001;
    end else if (actUp && curVal < stepMax(step_ff, currentMode)) begin
      nxtVal = curVal + 14'h0001;
    end else if (actDn && curVal > stepMin(step_ff, currentMode)) begin
      nxtVal = curVal - 14'h0001;
    end
  end

  // value store; span top and bottom are independent, so inverted spans stay legal
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < mmsa_pkg::STEP_SLOTS; i++) begin
        paramVal_ff[i] <= resetVal(5'(i));
      end
    end else if (nxtStep != step_ff) begin
      if (nxtStep == mmsa_pkg::ST_TRIM_MENU) begin
        paramVal_ff[nxtStep] <= 14'h0000;
      end else begin
        paramVal_ff[nxtStep] <= clampVal(paramVal_ff[nxtStep], nxtStep, currentMode);
      end
    end else if (step_ff != mmsa_pkg::ST_OPER) begin
      paramVal_ff[step_ff] <= nxtVal;
    end
  end

  // one-second tick for the delay timers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      secCnt_ff <= '0;
      secTick_ff <= 1'b0;
    end else if (secCnt_ff == mmsa_pkg::CNT_W'(SEC_CYCLES - 1)) begin
      secCnt_ff <= '0;
      secTick_ff <= 1'b1;
    end else begin
      secCnt_ff <= secCnt_ff + 1'b1;
      secTick_ff <= 1'b0;
    end
  end

  // blink: each step opens on its name, then alternates at a fixed rate
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      blinkCnt_ff <= '0;
      showName_ff <= 1'b0;
    end else if (nxtStep == mmsa_pkg::ST_OPER) begin
      blinkCnt_ff <= '0;
      showName_ff <= 1'b0;
    end else if (nxtStep != step_ff) begin
      blinkCnt_ff <= '0;
      showName_ff <= 1'b1;
    end else if (blinkCnt_ff == mmsa_pkg::CNT_W'(BLINK_CYC - 1)) begin
      blinkCnt_ff <= '0;
      showName_ff <= !showName_ff;
    end else begin
      blinkCnt_ff <= blinkCnt_ff + 1'b1;
    end
  end

  // display value; limit views are read-only, they touch no store slot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shownValue_ff <= 14'h0000;
    end else if (step_ff != mmsa_pkg::ST_OPER) begin
      shownValue_ff <= curVal;
    end else if (keys == mmsa_pkg::COMBO_UP) begin
      shownValue_ff <= paramVal_ff[mmsa_pkg::ST_LIM1];
    end else if (keys == mmsa_pkg::COMBO_DN) begin
      shownValue_ff <= paramVal_ff[mmsa_pkg::ST_LIM2];
    end else begin
      shownValue_ff <= reading;
    end
  end

  // one checker per limit; only the first two get delays
  for (genvar g = 0; g < 4; g++) begin : g_limit
    localparam mmsa_pkg::mmsa_step_type LIM_ST = (g == 0) ? mmsa_pkg::ST_LIM1 :
      (g == 1) ? mmsa_pkg::ST_LIM2 : (g == 2) ? mmsa_pkg::ST_LIM3 : mmsa_pkg::ST_LIM4;
    localparam mmsa_pkg::mmsa_step_type DB_ST = (g == 0) ? mmsa_pkg::ST_DB1 :
      (g == 1) ? mmsa_pkg::ST_DB2 : (g == 2) ? mmsa_pkg::ST_DB3 : mmsa_pkg::ST_DB4;
    localparam mmsa_pkg::mmsa_step_type MK_ST = (g == 0) ? mmsa_pkg::ST_MAKE1 : mmsa_pkg::ST_MAKE2;
    localparam mmsa_pkg::mmsa_step_type BK_ST = (g == 0) ? mmsa_pkg::ST_BRK1 : mmsa_pkg::ST_BRK2;
    mmsa_limit_alarm u_alarm (
      .clk(clk),
      .resetn(resetn),
      .secTick(secTick_ff),
      .reading(reading),
      .limitVal(paramVal_ff[LIM_ST]),
      .deadband(paramVal_ff[DB_ST]),
      .senseHigh(paramVal_ff[mmsa_pkg::ST_SENSE][3-g]),
      .makeDelay((g < 2) ? paramVal_ff[MK_ST] : 14'h0000),
      .breakDelay((g < 2) ? paramVal_ff[BK_ST] : 14'h0000),
      .alarmOut(alarm[g])
    );
  end

  assign menuStep = step_ff;
  assign showName = showName_ff;
  assign shownValue = shownValue_ff;
  assign relayDrive = alarm;
  assign trimEnabled = paramVal_ff[mmsa_pkg::ST_TRIM_MENU][0];
  assign outputBottomTrim = paramVal_ff[mmsa_pkg::ST_TRIM_LOW];
  assign outputTopTrim = paramVal_ff[mmsa_pkg::ST_TRIM_HIGH];
  assign pulsesEachTurn = paramVal_ff[mmsa_pkg::ST_PULSES];
  assign resolutionChoice = paramVal_ff[mmsa_pkg::ST_RANGE][1:0];
  assign lampIntensity = paramVal_ff[mmsa_pkg::ST_LAMP][1:0];
  assign spanTopReading = paramVal_ff[mmsa_pkg::ST_SPAN_TOP];
  assign spanBottomReading = paramVal_ff[mmsa_pkg::ST_SPAN_BOT];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_view_limit: assert property (
    (step_ff == mmsa_pkg::ST_OPER && keys == mmsa_pkg::COMBO_UP)
    |=> shownValue_ff == $past(paramVal_ff[mmsa_pkg::ST_LIM1]))
    else $error("up key alone does not show limit one");

  a_up_increments: assert property (
    (step_ff != mmsa_pkg::ST_OPER && step_ff != mmsa_pkg::ST_TRIM_MENU && actUp &&
     $stable(currentMode) && curVal < stepMax(step_ff, currentMode))
    |=> curVal == $past(curVal) + 14'h0001)
    else $error("up press did not increment");

  a_down_decrements: assert property (
    (step_ff != mmsa_pkg::ST_OPER && step_ff != mmsa_pkg::ST_TRIM_MENU && actDn &&
     $stable(currentMode) && curVal > stepMin(step_ff, currentMode))
    |=> curVal == $past(curVal) - 14'h0001)
    else $error("down press did not decrement");

  a_skip_trim: assert property (
    (step_ff == mmsa_pkg::ST_OPER && actCal && !outFitted) |=> step_ff == mmsa_pkg::ST_PULSES)
    else $error("calibration entry did not skip trim");

  a_trim_high_range: assert property (
    (step_ff == mmsa_pkg::ST_TRIM_HIGH && currentMode && $stable(currentMode))
    |-> paramVal_ff[mmsa_pkg::ST_TRIM_HIGH] inside {[mmsa_pkg::TRIM_MA_MIN:mmsa_pkg::TRIM_MA_MAX]})
    else $error("high trim outside mA range");

  a_pulses_range: assert property (
    step_ff == mmsa_pkg::ST_PULSES
    |-> paramVal_ff[mmsa_pkg::ST_PULSES] inside {[mmsa_pkg::PULSES_MIN:mmsa_pkg::VAL_MAX]})
    else $error("pulses each turn out of range");

  a_sense_exit: assert property (
    (step_ff == mmsa_pkg::ST_SENSE && actProg) |=> step_ff == mmsa_pkg::ST_OPER ##1 !showName_ff)
    else $error("program on sense step did not exit");

  a_name_first: assert property (
    (step_ff != mmsa_pkg::ST_OPER && $changed(step_ff)) |-> showName_ff)
    else $error("new step did not open on its name");
endmodule

/* design/mmsa_pkg.sv */
package mmsa_pkg;
  // system clock rate and the derived timing counts
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int TICK_PERIOD_MS = 1000; // delay timers count whole seconds
  localparam int SECOND_CYCLES = CLK_FREQ_HZ / 1000 * TICK_PERIOD_MS;
  localparam int BLINK_HALF_MS = 500; // name and value each shown this long
  localparam int BLINK_CYCLES = CLK_FREQ_HZ / 1000 * BLINK_HALF_MS;
  localparam int CNT_W = 25; // width of the tick and blink counters
  localparam int VAL_W = 14; // every parameter fits 0..9999

  // parameter ranges
  localparam logic [13:0] VAL_MAX = 14'h270F; // 9999
  localparam logic [13:0] VAL_MIN = 14'h0000;
  localparam logic [13:0] PULSES_MIN = 14'h0001;
  localparam logic [13:0] TRIM_MA_MIN = 14'h00AA; // 17.0 mA in 0.1 mA
  localparam logic [13:0] TRIM_MA_MAX = 14'h00D2; // 21.0 mA in 0.1 mA
  localparam logic [13:0] TRIM_V_MIN = 14'h0320; // 8.00 V in 0.01 V
  localparam logic [13:0] TRIM_V_MAX = 14'h0406; // 10.30 V in 0.01 V
  localparam logic [13:0] SWITCH_MAX = 14'h0001; // trim menu off/on
  localparam logic [13:0] RANGE_MAX = 14'h0002; // three resolutions
  localparam logic [13:0] LAMP_MAX = 14'h0003; // four brightness levels
  localparam logic [13:0] SENSE_MAX = 14'h000F; // one flag per limit

  // values after reset
  localparam logic [13:0] RST_PULSES = 14'h0001;
  localparam logic [13:0] RST_RANGE = 14'h0001;
  localparam logic [13:0] RST_LAMP = 14'h0003;
  localparam logic [13:0] RST_SPAN_TOP = 14'h270F;
  localparam logic [13:0] RST_OTHER = 14'h0000;

  // key combinations seen at release, bits {down, up, program}
  localparam logic [2:0] COMBO_PROG = 3'h1;
  localparam logic [2:0] COMBO_UP = 3'h2;
  localparam logic [2:0] COMBO_DN = 3'h4;
  localparam logic [2:0] COMBO_CAL = 3'h3;
  localparam logic [2:0] COMBO_SETP = 3'h5;

  localparam int NUM_LIMITS = 4;
  localparam int STEP_SLOTS = 32;

  // menu steps; the code also indexes the parameter store
  typedef enum logic [4:0] {
    ST_OPER = 5'h00, ST_TRIM_MENU = 5'h01, ST_TRIM_LOW = 5'h02, ST_TRIM_HIGH = 5'h03,
    ST_PULSES = 5'h04, ST_RANGE = 5'h05, ST_LAMP = 5'h06, ST_SPAN_TOP = 5'h07,
    ST_SPAN_BOT = 5'h08, ST_LIM1 = 5'h09, ST_MAKE1 = 5'h0A, ST_BRK1 = 5'h0B,
    ST_DB1 = 5'h0C, ST_LIM2 = 5'h0D, ST_MAKE2 = 5'h0E, ST_BRK2 = 5'h0F,
    ST_DB2 = 5'h10, ST_LIM3 = 5'h11, ST_DB3 = 5'h12, ST_LIM4 = 5'h13,
    ST_DB4 = 5'h14, ST_SENSE = 5'h15
  } mmsa_step_type;
endpackage

/* testbench/mmsa_keys.sv */
`timescale 1ns/1ps
module mmsa_keys (
  input wire logic clk, // system clock
  output logic keyProg, // program button
  output logic keyUp, // up button
  output logic keyDown // down button
);
  // an operator starts with no button pressed
  initial {keyDown, keyUp, keyProg} = 3'h0;
  // hold a combination for n cycles, changed just after an edge
  task automatic hold(input logic [2:0] c, input int n);
    @(posedge clk) {keyDown, keyUp, keyProg} <= c;
    repeat (n) @(posedge clk);
  endtask
  // press and release fully, so actions never merge
  task automatic push(input logic [2:0] c);
    hold(c, 2);
    hold(3'h0, 4);
  endtask
endmodule

/* testbench/mmsa_menu_alarms_tb.sv */
`timescale 1ns/1ps
module mmsa_menu_alarms_tb;
  logic clk, resetn, outFitted; // clock, reset, output option
  logic keyProg, keyUp, keyDown; // from the operator model
  logic [13:0] reading, shown, pulses, spanTop; // reading, display, stores
  logic [1:0] range, lamp; // stored choices
  logic [3:0] relays; // relay drive
  logic trimOn, nameOn, mode; // trim menu state, name phase, mA output
  logic [13:0] lowTrim, topTrim, spanBot; // trims and span bottom
  logic [3:0] fitted; // relays present
  mmsa_pkg::mmsa_step_type step; // current menu step
  int mismatches, tests_run; // verdict counters
  mmsa_keys u_keys (.clk(clk), .keyProg(keyProg), .keyUp(keyUp), .keyDown(keyDown));
  // short counts keep the seconds and blink quick
  mmsa_menu_alarms #(.SEC_CYCLES(10), .BLINK_CYC(4)) u_dut (
    .clk(clk), .resetn(resetn), .keyProg(keyProg), .keyUp(keyUp), .keyDown(keyDown),
    .outFitted(outFitted), .currentMode(mode), .relayFitted(fitted), .reading(reading),
    .menuStep(step), .showName(nameOn), .shownValue(shown), .trimEnabled(trimOn),
    .outputBottomTrim(lowTrim), .outputTopTrim(topTrim), .pulsesEachTurn(pulses),
    .resolutionChoice(range), .lampIntensity(lamp), .spanTopReading(spanTop),
    .spanBottomReading(spanBot), .relayDrive(relays));
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare one value
  task automatic chk(input string what, input logic [13:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    if (mismatches == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // stores after reset
  task automatic t_reset();
    chk("pulses", pulses, 14'h0001);
    chk("range", 14'(range), 14'h0001);
    chk("lamp", 14'(lamp), 14'h0003);
    chk("spantop", spanTop, 14'h270F);
  endtask
  // no output option: trim steps skipped, down at the floor saturates
  task automatic t_cal_bare();
    @(posedge clk) outFitted <= 1'b0;
    u_keys.push(mmsa_pkg::COMBO_CAL);
    chk("step", 14'(step), 14'h0004);
    u_keys.push(mmsa_pkg::COMBO_DN);
    chk("pulses", pulses, 14'h0001);
    u_keys.push(mmsa_pkg::COMBO_PROG);
    chk("step", 14'(step), 14'h0005);
    u_keys.push(mmsa_pkg::COMBO_UP);
    chk("range", 14'(range), 14'h0002);
    u_keys.push(mmsa_pkg::COMBO_PROG);
    u_keys.push(mmsa_pkg::COMBO_PROG);
    chk("step", 14'(step), 14'h0000);
  endtask
  // trim path, high trim pushed below its floor in the given output mode
  task automatic t_cal_trim(input logic m, input logic [13:0] hi, lo);
    @(posedge clk) outFitted <= 1'b1;
    mode <= m;
    u_keys.push(mmsa_pkg::COMBO_CAL);
    chk("step", 14'(step), 14'h0001);
    chk("name", 14'(nameOn), 14'h0001);
    repeat (2) @(posedge clk);
    chk("name", 14'(nameOn), 14'h0000);
    chk("off", shown, 14'h0000);
    u_keys.push(mmsa_pkg::COMBO_DN);
    chk("trim", 14'(trimOn), 14'h0001);
    u_keys.push(mmsa_pkg::COMBO_PROG);
    u_keys.push(mmsa_pkg::COMBO_UP);
    chk("low", lowTrim, lo);
    u_keys.push(mmsa_pkg::COMBO_PROG);
    u_keys.push(mmsa_pkg::COMBO_DN);
    chk("high", shown, hi);
    chk("top", topTrim, hi);
    u_keys.push(mmsa_pkg::COMBO_PROG);
    chk("step", 14'(step), 14'h0000);
  endtask
  // output fitted, trim left off: on through the span steps and out
  task automatic t_span();
    u_keys.push(mmsa_pkg::COMBO_CAL);
    repeat (4) u_keys.push(mmsa_pkg::COMBO_PROG);
    chk("step", 14'(step), 14'h0007);
    u_keys.push(mmsa_pkg::COMBO_DN);
    chk("spantop", spanTop, 14'h270E);
    u_keys.push(mmsa_pkg::COMBO_PROG);
    chk("step", 14'(step), 14'h0008);
    u_keys.push(mmsa_pkg::COMBO_UP);
    chk("spanbot", spanBot, 14'h0001);
    u_keys.push(mmsa_pkg::COMBO_PROG);
    chk("step", 14'(step), 14'h0000);
  endtask
  // only relay two fitted: entry and walk skip the absent limits
  task automatic t_absent();
    @(posedge clk) fitted <= 4'h2;
    u_keys.push(mmsa_pkg::COMBO_SETP);
    chk("step", 14'(step), 14'h000D);
    repeat (4) u_keys.push(mmsa_pkg::COMBO_PROG);
    chk("step", 14'(step), 14'h0015);
    u_keys.push(mmsa_pkg::COMBO_PROG);
    chk("step", 14'(step), 14'h0000);
  endtask
  // whole setpoint walk; limit one 1 with make 2, limit three 2 with deadband 2, four high
  task automatic t_setpoints();
    u_keys.push(mmsa_pkg::COMBO_SETP);
    for (int i = 0; i < 13; i++) begin
      chk("step", 14'(step), 14'(9 + i));
      if (i inside {0, 1, 8, 9, 12}) u_keys.push(mmsa_pkg::COMBO_UP);
      if (i inside {1, 8, 9}) u_keys.push(mmsa_pkg::COMBO_UP);
      if (i == 8) chk("lim3", shown, 14'h0002);
      u_keys.push(mmsa_pkg::COMBO_PROG);
    end
    chk("step", 14'(step), 14'h0000);
  endtask
  // relays across the deadband edges, view of limit one, make delay of limit one
  task automatic t_alarm();
    chk("relays", 14'(relays), 14'h0005);
    u_keys.hold(mmsa_pkg::COMBO_UP, 3);
    chk("view", shown, 14'h0001);
    u_keys.hold(3'h0, 4);
    @(posedge clk) reading <= 14'h0003;
    repeat (4) @(posedge clk);
    chk("relays", 14'(relays), 14'h000C);
    @(posedge clk) reading <= 14'h0004;
    repeat (4) @(posedge clk);
    chk("relays", 14'(relays), 14'h0008);
    @(posedge clk) reading <= 14'h0000;
    repeat (4) @(posedge clk);
    chk("relays", 14'(relays), 14'h000C);
    for (int n = 0; n < 40 && relays !== 4'hD; n++) @(posedge clk);
    chk("relays", 14'(relays), 14'h000D);
  endtask
  // main sequence
  initial begin
    resetn = 1'b0;
    outFitted = 1'b1;
    mode = 1'b1;
    fitted = 4'hF;
    reading = 14'h0000;
    mismatches = 0;
    tests_run = 0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_cal_bare();
    t_cal_trim(1'b1, 14'h00AA, 14'h0001);
    t_cal_trim(1'b0, 14'h0320, 14'h0002);
    t_span();
    t_setpoints();
    t_alarm();
    t_absent();
    close_out();
  end
endmodule
